// *** inc/rgc_pkg.sv ***
/*
   Constants of the receiver gain and signal-strength control block.
   Assumes: one 50 MHz clock, AXI4-Lite register access, 32-bit data.
*/
package rgc_pkg;
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] THRA_ADDR   = 8'h04;
   localparam logic [7:0] THRB_ADDR   = 8'h08;
   localparam logic [7:0] STAT_ADDR   = 8'h0C;
   localparam logic [7:0] CMD_ADDR    = 8'h10;
   localparam int CTRL_AUTO_BIT       = 0;
   localparam int CTRL_PRE_ADJ_BIT    = 1;
   localparam int CTRL_GATE_STR_BIT   = 2;
   localparam int CTRL_GATE_PRE_BIT   = 3;
   localparam int CTRL_AFC_BIT        = 4;
   localparam int CTRL_MANUAL_LSB     = 8;
   localparam int CTRL_AVG_LSB        = 12;
   localparam int CTRL_COMP_LSB       = 16;
   localparam int CMD_CAL_BIT         = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0101;
   localparam logic [31:0] THRA_RESET = 32'hC0A0_8060;
   localparam logic [31:0] THRB_RESET = 32'h0000_A0E0;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [2:0] GAIN_G1 = 3'h1;
   localparam logic [2:0] GAIN_G2 = 3'h2;
   localparam logic [2:0] GAIN_G3 = 3'h3;
   localparam logic [2:0] GAIN_G4 = 3'h4;
   localparam logic [2:0] GAIN_G5 = 3'h6;
   localparam logic [2:0] GAIN_G6 = 3'h7;
   localparam logic [9:0] STRENGTH_ZERO = 10'h100;
   typedef enum logic [2:0] {RGC_IDLE, RGC_GAIN, RGC_AFC, RGC_GATE, RGC_RUN} rgc_state_t;
endpackage

// *** src/rgc_gain_select.sv ***
/*
   Gain step register: manual field or threshold decision on the level.
   Assumes: thresholds ascending, level sampled on update.
*/
module rgc_gain_select
   import rgc_pkg::*;
(
   input  wire logic        clk,         // Core clock
   input  wire logic        rst_n,       // Async reset
   input  wire logic        auto_en,     // Auto gain on
   input  wire logic [2:0]  manual,      // Manual gain code
   input  wire logic        update,      // Take a decision now
   input  wire logic [7:0]  level,       // Input level, stronger is higher
   input  wire logic [39:0] thresholds,  // Five thresholds, low first
   output logic      [2:0]  step         // Applied gain code
);
   function automatic logic [2:0] pick(input logic [7:0] l, input logic [39:0] t);
      if (l <= t[7:0])
         return GAIN_G1;
      else if (l <= t[15:8])
         return GAIN_G2;
      else if (l <= t[23:16])
         return GAIN_G3;
      else if (l <= t[31:24])
         return GAIN_G4;
      else if (l <= t[39:32])
         return GAIN_G5;
      else
         return GAIN_G6;
   endfunction

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         step <= GAIN_G1;
      else if (!auto_en)
         step <= manual;
      else if (update)
         step <= pick(level, thresholds);
   end
endmodule

// *** src/rgc_strength_avg.sv ***
/*
   Block averager of the level samples over 2 to 256 samples.
   Assumes: one sample per level_valid pulse.
*/
module rgc_strength_avg
   import rgc_pkg::*;
(
   input  wire logic       clk,        // Core clock
   input  wire logic       rst_n,      // Async reset
   input  wire logic       restart,    // Drop partial block
   input  wire logic       in_valid,   // Sample strobe
   input  wire logic [7:0] in_level,   // Sample
   input  wire logic [2:0] count_code, // Samples 2^(code+1)
   output logic      [7:0] avg,        // Averaged level
   output logic            avg_valid   // One-cycle pulse on new average
);
   logic [8:0]  cnt;
   logic [15:0] sum;
   logic [15:0] next_sum;
   logic [8:0]  last;

   assign next_sum = sum + {8'h00, in_level};
   assign last     = 9'((9'h002 << count_code) - 9'h001);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt <= 9'h000;
         sum <= 16'h0000;
      end
      else if (restart)
      begin
         cnt <= 9'h000;
         sum <= 16'h0000;
      end
      else if (in_valid)
      begin
         if (cnt >= last)
         begin
            cnt <= 9'h000;
            sum <= 16'h0000;
         end
         else
         begin
            cnt <= cnt + 9'h001;
            sum <= next_sum;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         avg       <= 8'h00;
         avg_valid <= 1'b0;
      end
      else
      begin
         avg_valid <= in_valid && !restart && cnt >= last;
         if (in_valid && !restart && cnt >= last)
            avg <= 8'(next_sum >> (4'(count_code) + 4'h1));
      end
   end
endmodule

// *** src/rgc_top.sv ***
/*
   Receiver gain control, data release gating and signal strength.
   Assumes: AXI4-Lite master, front end giving level samples, preamble
   and frequency-correction handshakes synchronous to clk.
*/
// Local design decisions: register access over AXI4-Lite and the address map.
module rgc_top
   import rgc_pkg::*;
(
   input  wire logic        clk,              // 50 MHz core clock
   input  wire logic        rst_n,            // Async reset
   input  wire logic [7:0]  s_axi_awaddr,     // Write address
   input  wire logic [2:0]  s_axi_awprot,     // Unused protection
   input  wire logic        s_axi_awvalid,    // Write address valid
   output logic             s_axi_awready,    // Write address ready
   input  wire logic [31:0] s_axi_wdata,      // Write data
   input  wire logic [3:0]  s_axi_wstrb,      // Byte enables
   input  wire logic        s_axi_wvalid,     // Write data valid
   output logic             s_axi_wready,     // Write data ready
   output logic [1:0]       s_axi_bresp,      // Write response
   output logic             s_axi_bvalid,     // Write response valid
   input  wire logic        s_axi_bready,     // Write response ready
   input  wire logic [7:0]  s_axi_araddr,     // Read address
   input  wire logic [2:0]  s_axi_arprot,     // Unused protection
   input  wire logic        s_axi_arvalid,    // Read address valid
   output logic             s_axi_arready,    // Read address ready
   output logic [31:0]      s_axi_rdata,      // Read data
   output logic [1:0]       s_axi_rresp,      // Read response
   output logic             s_axi_rvalid,     // Read data valid
   input  wire logic        s_axi_rready,     // Read data ready
   input  wire logic        rx_enable,        // Receiver on
   input  wire logic [7:0]  input_level,      // Level, 0.5 dB, stronger higher
   input  wire logic        level_valid,      // Level sample strobe
   input  wire logic        preamble_active,  // Preamble being received
   input  wire logic        preamble_found,   // Preamble detected
   input  wire logic [7:0]  cal_reference,    // Expected level during calibration
   input  wire logic        afc_done,         // Frequency correction finished
   output logic             afc_start,        // Start frequency correction
   output logic [2:0]       gain_step,        // LNA gain code
   output logic             data_release,     // Demodulated data may flow
   output logic [7:0]       signal_strength_value // Reported strength
);
   logic [31:0] ctrl;
   logic [31:0] thra;
   logic [31:0] thrb;
   rgc_state_t  state;
   logic        cal_pending;
   logic        cal_done;
   logic signed [9:0] cal_error;
   logic        rx_on_d;
   logic        pre_seen;
   logic [7:0]  avg;
   logic        avg_valid;
   logic        gain_update;
   logic        strength_ok;
   logic        gate_open;
   logic        wr_go;
   logic        rd_go;
   logic        wr_hit;
   logic        rd_hit;
   logic [31:0] rd_word;
   logic        auto_on;
   logic        pre_adj;
   logic        gate_str;
   logic        gate_pre;
   logic        afc_on;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] din,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            r[8*i +: 8] = din[8*i +: 8];
      return r;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return a == CTRL_ADDR || a == THRA_ADDR || a == THRB_ADDR ||
             a == STAT_ADDR || a == CMD_ADDR;
   endfunction

   assign auto_on  = ctrl[CTRL_AUTO_BIT];
   assign pre_adj  = ctrl[CTRL_PRE_ADJ_BIT];
   assign gate_str = ctrl[CTRL_GATE_STR_BIT];
   assign gate_pre = ctrl[CTRL_GATE_PRE_BIT];
   assign afc_on   = ctrl[CTRL_AFC_BIT];

   // Write channel: address and data taken together
   assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign wr_hit        = wr_go && mapped(s_axi_awaddr);
   assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_arready = rd_go;
   assign rd_hit        = mapped(s_axi_araddr);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl <= CTRL_RESET;
         thra <= THRA_RESET;
         thrb <= THRB_RESET;
      end
      else if (wr_hit)
      begin
         if (s_axi_awaddr == CTRL_ADDR)
            ctrl <= merge(ctrl, s_axi_wdata, s_axi_wstrb) & 32'h001F_771F;
         if (s_axi_awaddr == THRA_ADDR)
            thra <= merge(thra, s_axi_wdata, s_axi_wstrb);
         if (s_axi_awaddr == THRB_ADDR)
            thrb <= merge(thrb, s_axi_wdata, s_axi_wstrb) & 32'h0000_FFFF;
      end
   end

   always_comb
   begin
      rd_word = 32'h0000_0000;
      case (s_axi_araddr)
         CTRL_ADDR: rd_word = ctrl;
         THRA_ADDR: rd_word = thra;
         THRB_ADDR: rd_word = thrb;
         STAT_ADDR: rd_word = {16'h0000, signal_strength_value, preamble_found,
                               cal_done, cal_pending, data_release, 1'b0, gain_step};
         default:   rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (rd_go)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // Calibration: capture level error against the reference
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cal_pending <= 1'b0;
         cal_done    <= 1'b0;
         cal_error   <= 10'sh000;
      end
      else if (wr_hit && s_axi_awaddr == CMD_ADDR && s_axi_wstrb[0] &&
               s_axi_wdata[CMD_CAL_BIT])
      begin
         cal_pending <= 1'b1;
         cal_done    <= 1'b0;
      end
      else if (cal_pending && level_valid)
      begin
         cal_pending <= 1'b0;
         cal_done    <= 1'b1;
         cal_error   <= $signed({2'b00, input_level}) -
                        $signed({2'b00, cal_reference});
      end
   end

   // Start-up sequence
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rx_on_d <= 1'b0;
      else
         rx_on_d <= rx_enable;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state <= RGC_IDLE;
      else if (!rx_enable)
         state <= RGC_IDLE;
      else
         case (state)
            RGC_IDLE:
               if (!rx_on_d)
                  state <= auto_on ? RGC_GAIN : (afc_on ? RGC_AFC : RGC_GATE);
            RGC_GAIN:
               if (!auto_on || level_valid)
                  state <= afc_on ? RGC_AFC : RGC_GATE;
            RGC_AFC:
               if (afc_done)
                  state <= RGC_GATE;
            RGC_GATE:
               if (gate_open)
                  state <= RGC_RUN;
            RGC_RUN:
               state <= RGC_RUN;
            default:
               state <= RGC_IDLE;
         endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         afc_start <= 1'b0;
      else
         afc_start <= rx_enable && afc_on && ((state == RGC_IDLE && !rx_on_d && !auto_on) ||
                      (state == RGC_GAIN && (!auto_on || level_valid)));
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pre_seen <= 1'b0;
      else if (state == RGC_IDLE)
         pre_seen <= 1'b0;
      else if (preamble_found)
         pre_seen <= 1'b1;
   end

   assign strength_ok = signal_strength_value <= thrb[15:8];
   always_comb
   begin
      case ({gate_str, gate_pre})
         2'b00:   gate_open = 1'b1;
         2'b01:   gate_open = pre_seen || preamble_found;
         2'b10:   gate_open = strength_ok;
         2'b11:   gate_open = (pre_seen || preamble_found) && strength_ok;
         default: gate_open = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         data_release <= 1'b0;
      else
         data_release <= rx_enable && (state == RGC_RUN ||
                         (state == RGC_GATE && gate_open));
   end

   assign gain_update = level_valid && (state == RGC_GAIN ||
                        (pre_adj && preamble_active &&
                         (state == RGC_GATE || state == RGC_RUN)));

   rgc_gain_select u_gain
   (
      .clk        (clk),
      .rst_n      (rst_n),
      .auto_en    (auto_on),
      .manual     (ctrl[CTRL_MANUAL_LSB +: 3]),
      .update     (gain_update),
      .level      (input_level),
      .thresholds ({thrb[7:0], thra}),
      .step       (gain_step)
   );

   rgc_strength_avg u_avg
   (
      .clk        (clk),
      .rst_n      (rst_n),
      .restart    (!rx_enable),
      .in_valid   (level_valid),
      .in_level   (input_level),
      .count_code (ctrl[CTRL_AVG_LSB +: 3]),
      .avg        (avg),
      .avg_valid  (avg_valid)
   );

   // Strength: 0.5 dB units, minus twice the 1 dB compensation
   always_ff @(posedge clk or negedge rst_n)
   begin
      logic signed [10:0] v;
      logic signed [10:0] comp;
      v    = 11'sh000;
      comp = 11'sh000;
      if (!rst_n)
         signal_strength_value <= 8'h00;
      else if (avg_valid)
      begin
         comp = 11'($signed(ctrl[CTRL_COMP_LSB +: 5])) <<< 1;
         v    = 11'($signed(STRENGTH_ZERO)) - $signed({3'b000, avg}) - comp -
                11'(cal_error);
         if (v < 0)
            signal_strength_value <= 8'h00;
         else if (v > 11'sh0FF)
            signal_strength_value <= 8'hFF;
         else
            signal_strength_value <= v[7:0];
      end
   end
endmodule

// *** sim/rgc_top_monitor.sv ***
/*
   Port checker of rgc_top: register handshakes, receiver start-up.
   Assumes: bound to rgc_top, one clock, async active-low reset.
*/
module rgc_top_monitor
   import rgc_pkg::*;
(
   input wire logic        clk,           // Clock
   input wire logic        rst_n,         // Reset
   input wire logic        s_axi_awvalid, // Addr valid
   input wire logic        s_axi_awready, // Addr ready
   input wire logic        s_axi_wvalid,  // Data valid
   input wire logic        s_axi_wready,  // Data ready
   input wire logic [1:0]  s_axi_bresp,   // Resp
   input wire logic        s_axi_bvalid,  // Resp valid
   input wire logic        s_axi_bready,  // Resp ready
   input wire logic        s_axi_arvalid, // Read valid
   input wire logic        s_axi_arready, // Read ready
   input wire logic [31:0] s_axi_rdata,   // Read data
   input wire logic        s_axi_rvalid,  // Data valid
   input wire logic        s_axi_rready,  // Data ready
   input wire logic        rx_enable,     // Receiver on
   input wire logic        afc_start,     // Correction start
   input wire logic [2:0]  gain_step,     // Gain code
   input wire logic        data_release   // Data gate
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_write_pair: assert property (s_axi_awready |-> s_axi_wready && s_axi_wvalid && !s_axi_bvalid)
      else $error("write channels taken apart");
   a_write_answer: assert property (s_axi_awready && s_axi_awvalid |=> s_axi_bvalid)
      else $error("write response late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |->
      s_axi_arready ##1 s_axi_rvalid)
      else $error("read answer late");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_gain_legal: assert property (gain_step != 3'h0 && gain_step != 3'h5)
      else $error("gain code undefined");
   a_release_off: assert property (!rx_enable |=> !data_release)
      else $error("release without receiver");
   a_release_start: assert property ($rose(rx_enable) |=> !data_release)
      else $error("release before start-up done");
   a_release_stand: assert property (data_release && rx_enable |=> data_release)
      else $error("release dropped");
   a_afc_pulse: assert property (afc_start |-> rx_enable ##1 !afc_start)
      else $error("correction start not a pulse");

   cover property ($rose(data_release));
   cover property (afc_start);
   cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind rgc_top rgc_top_monitor u_mon (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rx_enable, .afc_start, .gain_step,
   .data_release);

// *** sim/rgc_top_tb.sv ***
/*
   Self-checking bench of rgc_top: registers, gain, gating, strength.
   Assumes: rgc_pkg compiled first, 50 MHz clock.
*/
module rgc_top_tb
   import rgc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_n, awv, awr, wv, wrdy, bv, brdy, arv, arr, rv, rrdy;
   logic        rx, lv, pa, pf, afd, afs, rel;
   logic [1:0]  bre, rre;
   logic [2:0]  gs;
   logic [7:0]  awa, ara, lvl, cref, ssv;
   logic [31:0] wd, rd;
   int          failures, comparisons, cyc, nafc, e;
   logic [2:0]  gc [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
   logic [7:0]  lt [6] = '{8'h60, 8'h80, 8'h81, 8'hC0, 8'hE0, 8'hE1};
   logic [4:0]  cp [8] = '{5'h0F, 5'h1F, 5'h02, 5'h1E, 5'h04, 5'h00, 5'h06, 5'h10};

   rgc_top u_dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bre), .s_axi_bvalid(bv),
      .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rre), .s_axi_rvalid(rv),
      .s_axi_rready(rrdy), .rx_enable(rx), .input_level(lvl), .level_valid(lv),
      .preamble_active(pa), .preamble_found(pf), .cal_reference(cref), .afc_done(afd),
      .afc_start(afs), .gain_step(gs), .data_release(rel), .signal_strength_value(ssv));

   initial
   begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end

   always @(negedge clk)
   begin
      cyc++;
      if (afs)
         nafc++;
      if (cyc == 20000)
      begin
         failures++;
         results();
      end
   end

   task automatic results();
      if (failures == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(string n, logic [31:0] x, logic [31:0] s);
      comparisons++;
      if (s !== x)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, x, s);
      end
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
      logic ta;
      logic tw;
      ta = 1'h0;
      tw = 1'h0;
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      brdy <= 1'h1;
      while (!ta || !tw)
      begin
         @(negedge clk);
         ta = ta || awr;
         tw = tw || wrdy;
         @(posedge clk);
         if (ta)
            awv <= 1'h0;
         if (tw)
            wv <= 1'h0;
      end
      do @(negedge clk); while (!bv);
      @(posedge clk);
      brdy <= 1'h0;
      chk("bresp", r, bre);
      @(posedge clk);
   endtask

   task automatic rdc(logic [7:0] a, logic [31:0] m, logic [31:0] x, logic [1:0] r);
      ara <= a;
      arv <= 1'h1;
      rrdy <= 1'h1;
      do @(negedge clk); while (!arr);
      @(posedge clk);
      arv <= 1'h0;
      do @(negedge clk); while (!rv);
      @(posedge clk);
      rrdy <= 1'h0;
      chk("rresp", r, rre);
      chk("rdata", x, rd & m);
      @(posedge clk);
   endtask

   task automatic smp(logic [7:0] l);
      lvl <= l;
      lv <= 1'h1;
      @(posedge clk);
      lv <= 1'h0;
      @(posedge clk);
   endtask

   task automatic rxs(logic on);
      rx <= on;
      repeat (4) @(posedge clk);
   endtask

   initial
   begin
      rst_n = 1'h0;
      {awv, wv, brdy, arv, rrdy, rx, lv, pa, pf, afd} = '0;
      {awa, ara, lvl, cref, wd} = '0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      chk("gain", 3'h1, gs);
      rdc(CTRL_ADDR, '1, 32'h0000_0101, RESP_OKAY);
      rdc(THRA_ADDR, '1, 32'hC0A0_8060, RESP_OKAY);
      rdc(THRB_ADDR, '1, 32'h0000_A0E0, RESP_OKAY);
      rdc(CMD_ADDR, '1, 32'h0, RESP_OKAY);
      rdc(8'h20, '1, 32'h0, RESP_SLVERR);
      wr(8'h20, 32'hFFFF_FFFF, RESP_SLVERR);
      for (int i = 0; i < 6; i++)
      begin
         wr(CTRL_ADDR, {21'h0, gc[i], 8'h00}, RESP_OKAY);
         repeat (2) @(posedge clk);
         chk("manual gain", gc[i], gs);
      end
      // Auto gain with frequency correction, every gain code
      wr(CTRL_ADDR, 32'h0000_0011, RESP_OKAY);
      for (int i = 0; i < 6; i++)
      begin
         e = nafc;
         rxs(1'h1);
         smp(lt[i]);
         chk("auto gain", gc[i], gs);
         chk("afc start", e + 1, nafc);
         repeat (3) @(posedge clk);
         chk("early release", 1'h0, rel);
         afd <= 1'h1;
         @(posedge clk);
         afd <= 1'h0;
         repeat (3) @(posedge clk);
         chk("release", 1'h1, rel);
         rxs(1'h0);
         chk("release off", 1'h0, rel);
      end
      for (int p = 0; p < 2; p++)
      begin
         wr(CTRL_ADDR, {30'h0, p[0], 1'h1}, RESP_OKAY);
         rxs(1'h1);
         smp(8'h60);
         repeat (3) @(posedge clk);
         pa <= 1'h1;
         smp(8'hE1);
         chk("preamble gain", p ? 3'h7 : 3'h1, gs);
         pa <= 1'h0;
         rxs(1'h0);
      end
      // Gate modes; stale strength left weak between runs
      wr(THRB_ADDR, 32'h0000_20E0, RESP_OKAY);
      wr(CTRL_ADDR, 32'h0000_0100, RESP_OKAY);
      rxs(1'h1);
      smp(8'h10);
      smp(8'h10);
      rxs(1'h0);
      for (int m = 0; m < 4; m++)
      begin
         wr(CTRL_ADDR, {20'h0, 4'h1, 4'h0, m[0], m[1], 2'h0}, RESP_OKAY);
         rxs(1'h1);
         chk("gate", m == 0, rel);
         pf <= 1'h1;
         repeat (3) @(posedge clk);
         chk("gate preamble", !m[1], rel);
         smp(8'hF0);
         smp(8'hF0);
         repeat (2) @(posedge clk);
         chk("gate strength", 1'h1, rel);
         chk("strength", 8'h10, ssv);
         pf <= 1'h0;
         smp(8'h10);
         smp(8'h10);
         @(posedge clk);
         chk("strength weak", 8'hF0, ssv);
         rxs(1'h0);
      end
      // Every block length; a short block would end on the high half
      for (int c = 0; c < 8; c++)
      begin
         wr(CTRL_ADDR, {11'h0, cp[c], 1'h0, c[2:0], 12'h100}, RESP_OKAY);
         rxs(1'h1);
         for (int k = 0; k < (2 << c); k++)
            smp(k < (1 << c) ? 8'h20 : 8'h60);
         @(posedge clk);
         e = 192 - 2 * $signed(cp[c]);
         chk("strength avg", e[7:0], ssv);
         rxs(1'h0);
      end
      wr(CTRL_ADDR, 32'h0000_0100, RESP_OKAY);
      cref <= 8'h40;
      wr(CMD_ADDR, 32'h0000_0001, RESP_OKAY);
      smp(8'h48);
      rdc(STAT_ADDR, 32'h40, 32'h40, RESP_OKAY);
      rxs(1'h1);
      smp(8'h20);
      smp(8'h60);
      @(posedge clk);
      chk("calibrated", 8'hB8, ssv);
      results();
   end
endmodule
